// File: rtl/adc_host_pkg.sv
`default_nettype none
package adc_host_pkg;
    // software register offsets (word index on the plain port)
    localparam logic [3:0] CONTROL_OFFSET = 4'h0;
    localparam logic [3:0] SETUP_OFFSET = 4'h1;
    localparam logic [3:0] STATUS_OFFSET = 4'h2;
    localparam logic [3:0] RESULT_OFFSET = 4'h3;
    localparam logic [3:0] ECHO_OFFSET = 4'h4;
    localparam logic [3:0] TIMING_OFFSET = 4'h5;
    // control register fields
    localparam int START_BIT = 0;
    localparam int ECHO_READ_BIT = 1;
    localparam int BUSY_MODE_BIT = 2;
    localparam int PRELOAD_BIT = 3;
    // status register fields
    localparam int BUSY_BIT = 0;
    localparam int DONE_BIT = 1;
    localparam int PRELOAD_LEFT_LSB = 2;
    // setup word layout
    localparam int SETUP_WIDTH = 14;
    localparam int UPDATE_BIT = 13;
    localparam int TOPOLOGY_MSB = 12;
    localparam int TOPOLOGY_LSB = 10;
    localparam int CHANNEL_MSB = 9;
    localparam int CHANNEL_LSB = 7;
    localparam int FILTER_BIT = 6;
    localparam int SOURCE_MSB = 5;
    localparam int SOURCE_LSB = 3;
    localparam int SCAN_MSB = 2;
    localparam int SCAN_LSB = 1;
    localparam int ECHO_BIT = 0;
    localparam logic [13:0] SETUP_ALL_ONES = 14'h3fff;
    localparam logic [13:0] SETUP_RESET = 14'h0000;
    // frame lengths in serial clock cycles
    localparam int RESULT_BITS = 16;
    localparam logic [5:0] RESULT_EDGES = 6'h0f;
    localparam logic [5:0] RESULT_EDGES_BUSY = 6'h10;
    localparam logic [5:0] ECHO_EDGES = 6'h0e;
    localparam logic [1:0] PRELOAD_CONVERSIONS = 2'h2;
    // timing
    localparam int CLOCK_MHZ = 100;
    localparam int QUIET_BEFORE_NS = 30;
    localparam int QUIET_AFTER_NS = 10;
    localparam logic [7:0] QUIET_BEFORE_CYCLES = 8'((QUIET_BEFORE_NS * CLOCK_MHZ + 999) / 1000);
    localparam logic [7:0] QUIET_AFTER_CYCLES = 8'((QUIET_AFTER_NS * CLOCK_MHZ + 999) / 1000);
    localparam logic [7:0] SCK_HALF_RESET = 8'h04;
    localparam logic [15:0] CONV_WAIT_RESET = 16'h00c8;
    typedef enum logic [2:0]
    {
        IDLE = 3'b000,
        QUIET_PRE = 3'b001,
        STROBE_HIGH = 3'b011,
        CONVERTING = 3'b010,
        SHIFTING = 3'b110,
        FINISH = 3'b111
    } state_type;
endpackage : adc_host_pkg
`default_nettype wire

// File: rtl/adc_host.sv
// Contract
// - setup word sent msb first, 14 rising edges
// - echo needs 14 more edges after result
// - clock data only while strobe low
// - strobe rise starts conversion, then return low
// - two dummy conversions before setup valid
// - serial input high two conversions loads ones
// - finish serial activity before safe-access limit
// - write setup before safe-access limit
// - pins quiet 30 ns before, 10 after
// - serial clock gated, runs only in bursts
// - acquisition access fits acquisition phase
// - spanning access split in two bursts
// - strobe held low during power-up
//
// Our own choices: the plain strobed port and the placing of the registers.
`default_nettype none
module adc_host
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [3:0] address,
    input wire logic [31:0] write_data,
    input wire logic write_strobe,
    input wire logic read_strobe,
    output logic [31:0] read_data,
    output logic conversion_strobe,
    output logic serial_clock,
    output logic serial_data_in,
    input wire logic serial_result_output
);
    // software state
    logic [13:0] setup_word, next_setup_word;
    logic echo_read, next_echo_read;
    logic busy_mode, next_busy_mode;
    logic [7:0] sck_half, next_sck_half;
    logic [15:0] conv_wait, next_conv_wait;
    logic [15:0] result, next_result;
    logic [13:0] echo_word, next_echo_word;
    logic done, next_done;
    logic [1:0] preload_left, next_preload_left;
    logic [31:0] next_read_data;
    // sequencer state
    adc_host_pkg::state_type state, next_state;
    logic [15:0] count, next_count;
    logic [7:0] div, next_div;
    logic [5:0] edges, next_edges;
    logic [29:0] shift_out, next_shift_out;
    logic next_conversion_strobe, next_serial_clock, next_serial_data_in;
    // sampler for the result pin, three stages
    logic [2:0] sdo_sync;
    logic sdo_level, next_sdo_level;
    logic half_tick;
    logic [5:0] frame_edges;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sdo_sync <= 3'h0;
            sdo_level <= 1'b0;
        end
        else
        begin
            sdo_sync <= {sdo_sync[1:0], serial_result_output};
            sdo_level <= next_sdo_level;
        end
    end

    always_comb
    begin
        next_sdo_level = sdo_level;
        if (sdo_sync[2] == sdo_sync[1])
        begin
            next_sdo_level = sdo_sync[1];
        end
    end

    assign half_tick = (div == 8'h00);
    // setup goes out on the rising edges, result on falling; echo adds 14
    assign frame_edges = (busy_mode ? adc_host_pkg::RESULT_EDGES_BUSY
                          : adc_host_pkg::RESULT_EDGES)
                         + (echo_read ? adc_host_pkg::ECHO_EDGES : 6'h00);

    always_comb
    begin
        next_setup_word = setup_word;
        next_echo_read = echo_read;
        next_busy_mode = busy_mode;
        next_sck_half = sck_half;
        next_conv_wait = conv_wait;
        next_done = done;
        next_preload_left = preload_left;
        next_result = result;
        next_echo_word = echo_word;
        next_state = state;
        next_count = count;
        next_div = div;
        next_edges = edges;
        next_shift_out = shift_out;
        next_conversion_strobe = conversion_strobe;
        next_serial_clock = serial_clock;
        next_serial_data_in = serial_data_in;
        next_read_data = 32'h0000_0000;
        if (read_strobe)
        begin
            case (address)
                adc_host_pkg::CONTROL_OFFSET:
                    next_read_data = {29'h0, busy_mode, echo_read, 1'b0};
                adc_host_pkg::SETUP_OFFSET:
                    next_read_data = {18'h0, setup_word};
                adc_host_pkg::STATUS_OFFSET:
                    next_read_data = {28'h0, preload_left, done, state != adc_host_pkg::IDLE};
                adc_host_pkg::RESULT_OFFSET:
                    next_read_data = {16'h0, result};
                adc_host_pkg::ECHO_OFFSET:
                    next_read_data = {18'h0, echo_word};
                adc_host_pkg::TIMING_OFFSET:
                    next_read_data = {sck_half, conv_wait, 8'h00};
                default:
                    next_read_data = 32'h0000_0000;
            endcase
        end
        if (write_strobe)
        begin
            case (address)
                adc_host_pkg::SETUP_OFFSET:
                    // field layout follows the device's setup word
                    next_setup_word = write_data[13:0];
                adc_host_pkg::TIMING_OFFSET:
                begin
                    next_sck_half = (write_data[31:24] == 8'h00) ? 8'h01 : write_data[31:24];
                    next_conv_wait = write_data[23:8];
                end
                default:
                    ;
            endcase
        end
        case (state)
            adc_host_pkg::IDLE:
            begin
                if (write_strobe && address == adc_host_pkg::CONTROL_OFFSET
                    && write_data[adc_host_pkg::START_BIT])
                begin
                    next_echo_read = write_data[adc_host_pkg::ECHO_READ_BIT];
                    next_busy_mode = write_data[adc_host_pkg::BUSY_MODE_BIT];
                    // two strobes with the input held high load all ones
                    if (write_data[adc_host_pkg::PRELOAD_BIT])
                    begin
                        next_preload_left = adc_host_pkg::PRELOAD_CONVERSIONS;
                    end
                    next_done = 1'b0;
                    next_count = {8'h00, adc_host_pkg::QUIET_BEFORE_CYCLES};
                    next_state = adc_host_pkg::QUIET_PRE;
                end
            end
            adc_host_pkg::QUIET_PRE:
            begin
                // clock and data stay still around the strobe rise
                if (count == 16'h0000)
                begin
                    next_conversion_strobe = 1'b1;
                    next_count = {8'h00, adc_host_pkg::QUIET_AFTER_CYCLES};
                    next_state = adc_host_pkg::STROBE_HIGH;
                end
                else
                begin
                    next_count = count - 16'h0001;
                end
            end
            adc_host_pkg::STROBE_HIGH:
            begin
                if (count == 16'h0000)
                begin
                    next_count = conv_wait;
                    next_state = adc_host_pkg::CONVERTING;
                end
                else
                begin
                    next_count = count - 16'h0001;
                end
            end
            adc_host_pkg::CONVERTING:
            begin
                // access after conversion end, so any clock rate with sck_half of 2 or more is safe
                if (count == 16'h0000)
                begin
                    next_conversion_strobe = 1'b0;
                    next_shift_out = (preload_left != 2'h0)
                                     ? {16'hffff, adc_host_pkg::SETUP_ALL_ONES}
                                     : {setup_word, 16'h0000};
                    next_serial_data_in = (preload_left != 2'h0) ? 1'b1 : setup_word[13];
                    next_edges = 6'h00;
                    next_div = sck_half;
                    next_state = adc_host_pkg::SHIFTING;
                end
                else
                begin
                    next_count = count - 16'h0001;
                end
            end
            adc_host_pkg::SHIFTING:
            begin
                // clock runs only inside the burst, strobe low throughout
                if (half_tick)
                begin
                    next_div = sck_half;
                    // device drives the next bit on the fall; sample before it
                    if (serial_clock || (edges == frame_edges && count != 16'h0000))
                    begin
                        if (edges < 6'(adc_host_pkg::RESULT_BITS))
                        begin
                            next_result = {result[14:0], sdo_level};
                        end
                        else
                        begin
                            next_echo_word = {echo_word[12:0], sdo_level};
                        end
                    end
                    if (serial_clock)
                    begin
                        next_serial_clock = 1'b0;
                        next_shift_out = {shift_out[28:0], 1'b0};
                        next_serial_data_in = (preload_left != 2'h0) ? 1'b1 : shift_out[28];
                        next_edges = edges + 6'h01;
                        // in busy mode the extra fall has already brought the last bit out
                        if (busy_mode && edges + 6'h01 == frame_edges)
                        begin
                            next_state = adc_host_pkg::FINISH;
                        end
                    end
                    else if (edges != frame_edges)
                    begin
                        next_serial_clock = 1'b1;
                    end
                    else if (count == 16'h0000)
                    begin
                        // last bit stands only after the final fall: wait a full period
                        // with the clock held low so the sampler has settled
                        next_count = 16'h0001;
                    end
                    else
                    begin
                        next_state = adc_host_pkg::FINISH;
                    end
                end
                else
                begin
                    next_div = div - 8'h01;
                end
            end
            adc_host_pkg::FINISH:
            begin
                // the result is of the conversion this frame's strobe started
                next_serial_data_in = 1'b0;
                next_done = 1'b1;
                if (preload_left != 2'h0)
                begin
                    next_preload_left = preload_left - 2'h1;
                end
                next_state = adc_host_pkg::IDLE;
            end
            default:
                next_state = adc_host_pkg::IDLE;
        endcase
    end

    // strobe resets low so the device powers up with it low
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            setup_word <= adc_host_pkg::SETUP_RESET;
            echo_read <= 1'b0;
            busy_mode <= 1'b0;
            sck_half <= adc_host_pkg::SCK_HALF_RESET;
            conv_wait <= adc_host_pkg::CONV_WAIT_RESET;
            result <= 16'h0000;
            echo_word <= 14'h0000;
            done <= 1'b0;
            preload_left <= 2'h0;
            read_data <= 32'h0000_0000;
            state <= adc_host_pkg::IDLE;
            count <= 16'h0000;
            div <= 8'h00;
            edges <= 6'h00;
            shift_out <= 30'h0;
            conversion_strobe <= 1'b0;
            serial_clock <= 1'b0;
            serial_data_in <= 1'b0;
        end
        else
        begin
            setup_word <= next_setup_word;
            echo_read <= next_echo_read;
            busy_mode <= next_busy_mode;
            sck_half <= next_sck_half;
            conv_wait <= next_conv_wait;
            result <= next_result;
            echo_word <= next_echo_word;
            done <= next_done;
            preload_left <= next_preload_left;
            read_data <= next_read_data;
            state <= next_state;
            count <= next_count;
            div <= next_div;
            edges <= next_edges;
            shift_out <= next_shift_out;
            conversion_strobe <= next_conversion_strobe;
            serial_clock <= next_serial_clock;
            serial_data_in <= next_serial_data_in;
        end
    end
    // assertions bind to the host only (chk in adc_host_assertions); the device model counts its own faults
endmodule : adc_host
`default_nettype wire

// File: test/adc_host_assertions.sv
`default_nettype none
module adc_host_assertions
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [3:0] address,
    input wire logic [31:0] write_data,
    input wire logic write_strobe,
    input wire logic read_strobe,
    input wire logic [31:0] read_data,
    input wire logic conversion_strobe,
    input wire logic serial_clock,
    input wire logic serial_data_in,
    input wire logic serial_result_output
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    sequence sck_high_phase;
        serial_clock [*2];
    endsequence
    sequence quiet_span;
        !serial_clock && !$past(serial_clock, 1) && !$past(serial_clock, 2)
            && !$past(serial_clock, 3);
    endsequence
    a_no_clock_strobe: assert property (conversion_strobe |-> !serial_clock)
        else $error("serial clock runs while strobe high");
    a_quiet_pre: assert property ($rose(conversion_strobe) |-> quiet_span)
        else $error("serial clock active just before strobe rise");
    a_din_quiet_pre: assert property ($rose(conversion_strobe) |->
        serial_data_in == $past(serial_data_in, 3))
        else $error("data line moved just before strobe rise");
    a_quiet_post: assert property ($rose(conversion_strobe) |=>
        $stable(serial_data_in) && !serial_clock)
        else $error("pins moved just after strobe rise");
    a_din_held_high: assert property (serial_clock |-> $stable(serial_data_in))
        else $error("data changed around a rising serial edge");
    a_sck_min_high: assert property ($rose(serial_clock) |-> sck_high_phase)
        else $error("serial clock high phase too short");
    a_strobe_pulse: assert property ($rose(conversion_strobe) |-> conversion_strobe [*2])
        else $error("strobe pulse too short");
    a_burst_follows: assert property ($fell(conversion_strobe) |-> ##[1:600] serial_clock)
        else $error("no burst after strobe returned low");
    a_read_idle_zero: assert property (!$past(read_strobe) |-> read_data == 32'h0)
        else $error("read data not zero outside answer cycle");
    a_unmapped_zero: assert property (read_strobe && address > 4'h5 |=> read_data == 32'h0)
        else $error("unmapped read returned data");
endmodule : adc_host_assertions
bind adc_host adc_host_assertions chk (.ref_clk, .reset_n, .address, .write_data,
    .write_strobe, .read_strobe, .read_data, .conversion_strobe, .serial_clock,
    .serial_data_in, .serial_result_output);
`default_nettype wire

// File: test/adc_device_model.sv
`default_nettype none
module adc_device_model
(
    input wire logic conversion_strobe,
    input wire logic serial_clock,
    input wire logic serial_data_in,
    output logic serial_result_output,
    output logic [7:0] fault_count
);
    timeunit 1ns;
    timeprecision 1ps;
    // arbitrary stand-in for the undefined power-up setup
    logic [13:0] active = 14'h1555;
    logic [13:0] shift_in = 14'h0;
    logic [29:0] stream = 30'h0;
    int rises = 0;
    int falls = 0;
    logic strobe_seen = 1'b0;
    initial fault_count = 8'h0;
    initial serial_result_output = 1'b0;
    // one process owns the result line: strobe edges and falling serial edges
    always @(conversion_strobe or negedge serial_clock)
    begin
        if (conversion_strobe && !strobe_seen)
        begin
            // result from the old setup; a queued word lands at this strobe rise, after the stream is built
            stream = {{active[9:7], active[12:0]} ^ 16'h5a5a, active};
            if (rises >= 14 && shift_in[13]) active = shift_in;
            rises = 0;
            falls = 0;
            serial_result_output = ~serial_result_output;
        end
        else if (!conversion_strobe && strobe_seen)
        begin
            serial_result_output = stream[29];
        end
        else if (!conversion_strobe && !serial_clock)
        begin
            // released line shows the inverse once the stream is used up
            falls++;
            serial_result_output = (falls < 30) ? stream[29 - falls] : ~serial_result_output;
        end
        strobe_seen = conversion_strobe;
    end
    always @(posedge serial_clock)
    begin
        if (conversion_strobe) fault_count = fault_count + 8'h1;
        else if (rises < 14)
        begin
            shift_in = {shift_in[12:0], serial_data_in};
            rises++;
        end
    end
endmodule : adc_device_model
`default_nettype wire

// File: test/adc_host_bench.sv
`default_nettype none
module adc_host_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, reset_n, write_strobe, read_strobe;
    logic conversion_strobe, serial_clock, serial_data_in, serial_result_output;
    logic [3:0] address;
    logic [31:0] write_data, read_data, d;
    logic [7:0] fault_count;
    logic [13:0] act, pend, w;
    int bad_count, total_checks, cycles, seed, pl;
    adc_host uut (.ref_clk(ref_clk), .reset_n(reset_n), .address(address),
        .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
        .read_data(read_data), .conversion_strobe(conversion_strobe),
        .serial_clock(serial_clock), .serial_data_in(serial_data_in),
        .serial_result_output(serial_result_output));
    adc_device_model dev (.conversion_strobe(conversion_strobe), .serial_clock(serial_clock),
        .serial_data_in(serial_data_in), .serial_result_output(serial_result_output),
        .fault_count(fault_count));
    always #5 ref_clk = ~ref_clk;
    task end_of_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    always @(posedge ref_clk) if (++cycles == 40000)
    begin
        bad_count++;
        end_of_test();
    end
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        address <= a;
        write_data <= v;
        write_strobe <= 1'b1;
        @(posedge ref_clk);
        write_strobe <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        address <= a;
        read_strobe <= 1'b1;
        @(posedge ref_clk);
        read_strobe <= 1'b0;
        #1 v = read_data;
    endtask : rd
    // one conversion plus access; the model mirrors the one-deep setup pipeline
    task frame(input logic [13:0] ws, input logic [3:0] ctl, input bit chk);
        logic [15:0] er;
        int n;
        wr(adc_host_pkg::SETUP_OFFSET, {18'h0, ws});
        wr(adc_host_pkg::CONTROL_OFFSET, {28'h0, ctl});
        if (ctl[adc_host_pkg::PRELOAD_BIT]) pl = 2;
        n = 0;
        d = 32'h0;
        while (d[adc_host_pkg::DONE_BIT] !== 1'b1 && n < 3000)
        begin
            rd(adc_host_pkg::STATUS_OFFSET, d);
            n++;
        end
        // a frame uses up one preload conversion while any are left; idle and done once the burst ends
        if (pl > 0) pl--;
        check("status", d, {28'h0, 2'(pl), 2'b10});
        rd(adc_host_pkg::CONTROL_OFFSET, d);
        check("control", d, {29'h0, ctl[2:1], 1'b0});
        er = {act[9:7], act[12:0]} ^ 16'h5a5a;
        if (chk)
        begin
            rd(adc_host_pkg::RESULT_OFFSET, d);
            if (ctl[adc_host_pkg::BUSY_MODE_BIT]) check("result", 32'(d[15:0]), 32'(er));
            else check("result", 32'(d[15:0]), 32'(er));
            if (ctl[adc_host_pkg::ECHO_READ_BIT])
            begin
                rd(adc_host_pkg::ECHO_OFFSET, d);
                check("echo", 32'(d[13:0]), 32'(act));
            end
        end
        if (pend[13]) act = pend;
        pend = ws;
    endtask : frame
    initial
    begin
        ref_clk = 1'b0;
        reset_n = 1'b0;
        address = 4'h0;
        write_data = 32'h0;
        write_strobe = 1'b0;
        read_strobe = 1'b0;
        bad_count = 0;
        total_checks = 0;
        cycles = 0;
        pl = 0;
        act = 14'h0;
        pend = 14'h0;
        seed = $urandom(93079);
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        rd(adc_host_pkg::STATUS_OFFSET, d);
        check("status", d, 32'h0);
        rd(adc_host_pkg::SETUP_OFFSET, d);
        check("setup", d, 32'h0);
        rd(adc_host_pkg::TIMING_OFFSET, d);
        check("timing", d, {adc_host_pkg::SCK_HALF_RESET, adc_host_pkg::CONV_WAIT_RESET, 8'h0});
        wr(4'he, 32'hffffffff);
        rd(4'he, d);
        check("unmapped", d, 32'h0);
        wr(adc_host_pkg::TIMING_OFFSET, {8'($urandom_range(4, 2)), 16'h0014, 8'h0});
        // two dummy conversions with the data line high fill the setup with ones
        frame(adc_host_pkg::SETUP_ALL_ONES, 4'h9, 0);
        frame(adc_host_pkg::SETUP_ALL_ONES, 4'h1, 0);
        act = adc_host_pkg::SETUP_ALL_ONES;
        pend = adc_host_pkg::SETUP_ALL_ONES;
        for (int ch = 0; ch < 9; ch++)
        begin
            w = {ch != 3, 3'($urandom), 3'(ch), 7'($urandom)};
            frame(w, 4'h7, 1);
        end
        frame({1'b1, 13'($urandom)}, 4'h1, 1);
        frame({1'b1, 13'($urandom)}, 4'h5, 1);
        frame({1'b1, 13'($urandom)}, 4'h3, 1);
        frame(14'h0, 4'h7, 1);
        check("device faults", 32'(fault_count), 32'h0);
        end_of_test();
    end
endmodule : adc_host_bench
`default_nettype wire
